/* File: src/lrc_regulator_ctrl.sv */
// Register bank and enable logic of the first linear regulator.
// Assumes a serial register front end presents byte accesses synchronous to clk.
`timescale 1ns/1ps
module lrc_regulator_ctrl
#(
  parameter int PIN_COUNT = 8
)
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // Register port (byte wide, one-cycle strobes)
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rvalid,
  // Factory straps and system state
  input  wire logic [2:0]                   power_up_slot,
  input  wire logic                         boot_stage_0,
  input  wire logic                         boot_stage_25,
  input  wire logic                         boot_stage_50,
  input  wire logic                         boot_done,
  input  wire logic                         hard_reset_mode,
  input  wire logic                         off_mode,
  // Control pins
  input  wire logic [PIN_COUNT-1:0]         multipurpose_control_pin,
  // Analogue stage controls
  output logic                              regulator_enable,
  output logic                              switch_mode,
  output logic                              active_discharge,
  output logic                              passive_discharge,
  output logic      [lrc_pkg::LRC_VCODE_W-1:0] output_voltage_code,
  output logic      [10:0]                  output_voltage_mv
);
  import lrc_pkg::*;

  // Pin select register is one byte wide, so no other pin count can be served
  if (PIN_COUNT != 8)
  begin : g_pin_count_check
    $error("PIN_COUNT must be 8");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [1:0]           software_enable_select;
  logic                 pin0_function_select;
  logic                 pin0_function_enable;
  logic                 active_discharge_select;
  logic                 switch_mode_select;
  logic                 passive_discharge_select;
  logic [LRC_VCODE_W-1:0] vcode;
  logic [7:0]           pin_enable_select;
  logic                 next_enable;
  logic                 next_mode_req;
  logic                 enable_q;
  logic                 mode_latched;

  // Voltage in mV for a code; codes past the top clamp, as supply limits them
  function automatic logic [10:0] lrc_code_to_mv(input logic [5:0] code);
    logic [5:0] c;
    c = (code > LRC_VCODE_MAX) ? LRC_VCODE_MAX : code;
    return 11'(LRC_VOUT_BASE_MV + LRC_VOUT_STEP_MV * int'(c));
  endfunction : lrc_code_to_mv

  // Enable select register write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      software_enable_select <= LRC_SWEN_RESET;
    else if (reg_wr && reg_addr == LRC_ADDR_ENABLE_SELECT)
      software_enable_select <= reg_wdata[LRC_SWEN_LSB +: 2];  // Slot bits read only
  end

  // Configuration register write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      {pin0_function_select, pin0_function_enable, active_discharge_select,
       switch_mode_select, passive_discharge_select} <= LRC_CFG_RESET;
    else if (reg_wr && reg_addr == LRC_ADDR_CONFIG)
    begin
      pin0_function_select     <= reg_wdata[LRC_PIN0_FSEL_BIT];
      pin0_function_enable     <= reg_wdata[LRC_PIN0_FEN_BIT];
      active_discharge_select  <= reg_wdata[LRC_ACT_DSC_BIT];
      switch_mode_select       <= reg_wdata[LRC_MODE_BIT];
      passive_discharge_select <= reg_wdata[LRC_PSV_DSC_BIT];
    end
  end

  // Voltage code and pin select writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vcode             <= LRC_VCODE_RESET;
      pin_enable_select <= LRC_PINSEL_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == LRC_ADDR_VOLTAGE_CODE)
        vcode <= reg_wdata[LRC_VCODE_W-1:0];
      if (reg_addr == LRC_ADDR_PIN_SELECT)
        pin_enable_select <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Registered read data, answered the cycle after the strobe; unmapped reads 0
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        case (reg_addr)
          LRC_ADDR_ENABLE_SELECT:
            reg_rdata <= {power_up_slot, 3'h0, software_enable_select};
          LRC_ADDR_CONFIG:
            reg_rdata <= {3'h0, pin0_function_select, pin0_function_enable,
                          active_discharge_select, switch_mode_select,
                          passive_discharge_select};
          LRC_ADDR_VOLTAGE_CODE:
            reg_rdata <= {2'h0, vcode};
          LRC_ADDR_PIN_SELECT:
            reg_rdata <= pin_enable_select;
          default:
            reg_rdata <= 8'h00;
        endcase
    end
  end

  // ----------------------------------------------------------------------
  // Enable resolution
  // ----------------------------------------------------------------------
  // Slot decides first; software select only in slot 111; reserved codes mean off
  always_comb
  begin
    next_enable = 1'b0;
    case (power_up_slot)
      LRC_SLOT_P0:  next_enable = boot_stage_0;
      LRC_SLOT_P25: next_enable = boot_stage_25;
      LRC_SLOT_P50: next_enable = boot_stage_50;
      LRC_SLOT_SOFT:
        if (boot_done)
          case (software_enable_select)
            LRC_SWEN_ON:   next_enable = 1'b1;
            LRC_SWEN_PINS: next_enable = |(pin_enable_select & multipurpose_control_pin);
            default:       next_enable = 1'b0;
          endcase
      default:      next_enable = 1'b0;
    endcase
    next_mode_req = switch_mode_select;
    // Pin 0 special function applies only when its enable bit is set
    if (pin0_function_enable)
    begin
      if (pin0_function_select)
      begin
        next_enable   = next_enable && multipurpose_control_pin[0];
        next_mode_req = 1'b1;
      end
      else
        next_mode_req = multipurpose_control_pin[0];
    end
  end

  // Enable flop keeps the analogue control free of decode glitches
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      enable_q <= 1'b0;
    else
      enable_q <= next_enable;
  end

  // Mode latch sees the registered enable so it only opens while truly off
  lrc_mode_latch u_mode_latch
  (
    .clk          (clk),
    .arst_n       (arst_n),
    .mode_request (next_mode_req),
    .reg_enable   (enable_q),
    .mode_active  (mode_latched)
  );

  // ----------------------------------------------------------------------
  // Outputs to the analogue stage
  // ----------------------------------------------------------------------
  // Discharge uses the unregistered enable so it follows the cause by one cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_discharge    <= 1'b0;
      passive_discharge   <= 1'b0;
      output_voltage_code <= LRC_VCODE_RESET;
      output_voltage_mv   <= 11'h000;
    end
    else
    begin
      active_discharge    <= hard_reset_mode
                             || (active_discharge_select && !next_enable);
      passive_discharge   <= hard_reset_mode || off_mode
                             || (passive_discharge_select && !next_enable);
      output_voltage_code <= vcode;
      output_voltage_mv   <= lrc_code_to_mv(vcode);
    end
  end

  // Switch mode drives pass device fully on/off; zero is normal regulation
  assign regulator_enable = enable_q;
  assign switch_mode      = mode_latched;

endmodule : lrc_regulator_ctrl

/* File: src/lrc_pkg.sv */
// Constants for the first linear regulator enable and configuration register bank.
// Assumes a serial register port front end that delivers byte-wide reads and writes.
//
// How it works
// - Read-only 3-bit power-up slot; 000 off, 010/011/100 staged, 111 software.
// - Software enable select acts only at slot 111; 00 off, 01 on, 10 pins.
// - Pin0 enable bit clear means pin0 function ignored; set activates pin0 function.
// - Function select: mode pin (low regulate, high switch) or enable pin.
// - Active discharge in hard reset; with bit set also when enable drops.
// - Mode bit 0 regulates; 1 makes a fully on/off load switch.
// - Mode bit latched internally; new value loads only while regulator disabled.
// - Passive discharge on entering off or hard reset; bit set adds enable low.
// - Six-bit voltage code, 0.5V plus 25mV per code, top 1.95V at 111010.
// - Each pin select bit lets its control pin drive the regulator enable.
// - Pin select bits honoured only at slot 111 and enable select 10.
// - Several selected pins combine by logical OR into the enable.
package lrc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] LRC_ADDR_ENABLE_SELECT = 8'h51;
  localparam logic [7:0] LRC_ADDR_CONFIG        = 8'h52;
  localparam logic [7:0] LRC_ADDR_VOLTAGE_CODE  = 8'h53;
  localparam logic [7:0] LRC_ADDR_PIN_SELECT    = 8'h54;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LRC_SLOT_LSB        = 5;
  localparam int LRC_SWEN_LSB        = 0;
  localparam int LRC_PIN0_FSEL_BIT   = 4;
  localparam int LRC_PIN0_FEN_BIT    = 3;
  localparam int LRC_ACT_DSC_BIT     = 2;
  localparam int LRC_MODE_BIT        = 1;
  localparam int LRC_PSV_DSC_BIT     = 0;
  localparam int LRC_VCODE_W         = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] LRC_SWEN_RESET   = 2'h0;
  localparam logic [4:0] LRC_CFG_RESET    = 5'h00;
  localparam logic [5:0] LRC_VCODE_RESET  = 6'h00;
  localparam logic [7:0] LRC_PINSEL_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LRC_SLOT_OFF  = 3'h0,
    LRC_SLOT_P0   = 3'h2,
    LRC_SLOT_P25  = 3'h3,
    LRC_SLOT_P50  = 3'h4,
    LRC_SLOT_SOFT = 3'h7
  } lrc_slot_t;

  typedef enum logic [1:0] {
    LRC_SWEN_OFF  = 2'h0,
    LRC_SWEN_ON   = 2'h1,
    LRC_SWEN_PINS = 2'h2
  } lrc_swen_t;

  // Voltage scale in millivolts
  localparam int         LRC_VOUT_BASE_MV = 500;
  localparam int         LRC_VOUT_STEP_MV = 25;
  localparam logic [5:0] LRC_VCODE_MAX    = 6'h3A;

endpackage : lrc_pkg

/* File: src/lrc_mode_latch.sv */
// Holds the switch-mode select seen by the analogue stage.
// Assumes reg_enable is the resolved regulator enable in the same clock domain.
`timescale 1ns/1ps
module lrc_mode_latch
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Control
  input  wire logic mode_request,
  input  wire logic reg_enable,
  // Result
  output logic      mode_active
);
  import lrc_pkg::*;

  // ----------------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------------
  // Changing pass-device mode under load would glitch the rail, so update waits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_active <= 1'b0;
    else if (!reg_enable)
      mode_active <= mode_request;
  end

endmodule : lrc_mode_latch

/* File: dv/lrc_regulator_ctrl_asserts.sv */
// Concurrent checks on the regulator control bank ports.
// Assumes binding to lrc_regulator_ctrl in a single clk domain.
`timescale 1ns/1ps
module lrc_regulator_ctrl_asserts
(
  // Clock, reset and read side of the register port
  input wire logic                            clk,
  input wire logic                            arst_n,
  input wire logic                            reg_rd,
  input wire logic [7:0]                      reg_addr,
  input wire logic [7:0]                      reg_rdata,
  input wire logic                            reg_rvalid,
  // Straps, modes and analogue controls
  input wire logic [2:0]                      power_up_slot,
  input wire logic                            hard_reset_mode,
  input wire logic                            off_mode,
  input wire logic                            regulator_enable,
  input wire logic                            switch_mode,
  input wire logic                            active_discharge,
  input wire logic                            passive_discharge,
  input wire logic [lrc_pkg::LRC_VCODE_W-1:0] output_voltage_code,
  input wire logic [10:0]                     output_voltage_mv
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_slot_read;
    reg_rd && reg_addr == 8'h51 |=> reg_rvalid && reg_rdata[7:5] == $past(power_up_slot);
  endproperty
  a_slot_read: assert property (p_slot_read) else $error("slot readback wrong");
  property p_slot_off; power_up_slot == 3'h0 |=> !regulator_enable; endproperty
  a_slot_off: assert property (p_slot_off) else $error("enabled in slot off");
  property p_slot_rsvd; power_up_slot inside {3'h1, 3'h5, 3'h6} |=> !regulator_enable; endproperty
  a_slot_rsvd: assert property (p_slot_rsvd) else $error("enabled by reserved slot");
  property p_rise;
    $rose(regulator_enable) |-> $past(power_up_slot) inside {3'h2, 3'h3, 3'h4, 3'h7};
  endproperty
  a_rise: assert property (p_rise) else $error("enable rose in bad slot");
  property p_act; hard_reset_mode |=> active_discharge; endproperty
  a_act: assert property (p_act) else $error("no active discharge in hard reset");
  property p_psv; off_mode || hard_reset_mode |=> passive_discharge; endproperty
  a_psv: assert property (p_psv) else $error("no passive discharge");
  // Output registers are still clear at the first edge after reset
  property p_mv;
    $past(arst_n) && output_voltage_code <= 6'h3A
      |-> output_voltage_mv == 11'h1F4 + 11'(output_voltage_code) * 11'h019;
  endproperty
  a_mv: assert property (p_mv) else $error("voltage scale wrong");
  property p_mv_top; $past(arst_n) && output_voltage_code > 6'h3A |-> output_voltage_mv == 11'h79E;
  endproperty
  a_mv_top: assert property (p_mv_top) else $error("voltage clamp wrong");
  property p_mode; $changed(switch_mode) |-> !$past(regulator_enable); endproperty
  a_mode: assert property (p_mode) else $error("mode moved while enabled");
  property p_rvalid; reg_rvalid |-> $past(reg_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("stray read valid");
  c_enable: cover property ($rose(regulator_enable));
  c_mode: cover property ($rose(switch_mode));
  c_act: cover property ($rose(active_discharge));
endmodule : lrc_regulator_ctrl_asserts

bind lrc_regulator_ctrl lrc_regulator_ctrl_asserts u_chk (.clk, .arst_n, .reg_rd, .reg_addr,
  .reg_rdata, .reg_rvalid, .power_up_slot, .hard_reset_mode, .off_mode, .regulator_enable,
  .switch_mode, .active_discharge, .passive_discharge, .output_voltage_code, .output_voltage_mv);

/* File: dv/lrc_regulator_ctrl_tb.sv */
// Self-checking bench for the regulator control bank.
// Assumes the checker is bound by its own file; one 200 MHz clock.
`timescale 1ns/1ps
module lrc_regulator_ctrl_tb;
  logic        clk, arst_n, reg_wr, reg_rd, reg_rvalid, boot_done, hard_reset_mode, off_mode;
  logic        boot_stage_0, boot_stage_25, boot_stage_50, regulator_enable, switch_mode;
  logic        active_discharge, passive_discharge;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, multipurpose_control_pin;
  logic [2:0]  power_up_slot;
  logic [5:0]  output_voltage_code;
  logic [10:0] output_voltage_mv;
  int          failures, total_checks, cycles;
  logic [5:0]  codes [4] = '{6'h00, 6'h01, 6'h3A, 6'h3F};

  lrc_regulator_ctrl #(.PIN_COUNT(8)) uut (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .power_up_slot, .boot_stage_0, .boot_stage_25,
    .boot_stage_50, .boot_done, .hard_reset_mode, .off_mode, .multipurpose_control_pin,
    .regulator_enable, .switch_mode, .active_discharge, .passive_discharge,
    .output_voltage_code, .output_voltage_mv);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task chk(input string what, input logic [10:0] e, input logic [10:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask : wr
  // Read data and valid are registered; valid stands only the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 11'h001, {10'h0, reg_rvalid});
    chk("rdata", {3'h0, e}, {3'h0, reg_rdata});
  endtask : rd
  // Enable lands two edges after a write; one more covers the mode latch
  task settle;
    repeat (4) @(posedge clk); #1;
  endtask : settle
  task en(input logic e);
    settle; chk("enable", {10'h0, e}, {10'h0, regulator_enable});
  endtask : en
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs;
    rd(8'h51, 8'h00); rd(8'h52, 8'h00); rd(8'h53, 8'h00); rd(8'h54, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h51, 8'hFF); rd(8'h51, 8'h03);
  endtask : t_regs
  task t_swen;
    @(posedge clk) power_up_slot <= 3'h7;
    boot_done <= 1'b1;
    en(1'b0);
    wr(8'h51, 8'h01);
    en(1'b1);
    @(posedge clk) power_up_slot <= 3'h0;
    en(1'b0);
    @(posedge clk) power_up_slot <= 3'h5;
    en(1'b0);
    @(posedge clk) power_up_slot <= 3'h7;
    boot_done <= 1'b0;
    en(1'b0);
    @(posedge clk) boot_done <= 1'b1;
    en(1'b1);
  endtask : t_swen
  task t_pins;
    wr(8'h54, 8'h81); wr(8'h51, 8'h02);
    @(posedge clk) multipurpose_control_pin <= 8'h80;
    en(1'b1);
    @(posedge clk) multipurpose_control_pin <= 8'h01;
    en(1'b1);
    @(posedge clk) multipurpose_control_pin <= 8'h02;
    en(1'b0);
    @(posedge clk) multipurpose_control_pin <= 8'h81;
    en(1'b1);
    @(posedge clk) power_up_slot <= 3'h0;
    en(1'b0);
    @(posedge clk) power_up_slot <= 3'h7;
    wr(8'h51, 8'h00);
    en(1'b0);
  endtask : t_pins
  // Boot stages rise in order; each staged slot waits for its own stage
  task t_staged;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) power_up_slot <= 3'(i + 2);
      {boot_stage_50, boot_stage_25, boot_stage_0} <= 3'((1 << i) - 1);
      en(1'b0);
      @(posedge clk) {boot_stage_50, boot_stage_25, boot_stage_0} <= 3'((2 << i) - 1);
      en(1'b1);
    end
    @(posedge clk) power_up_slot <= 3'h7;
  endtask : t_staged
  task t_mode;
    wr(8'h51, 8'h01); wr(8'h52, 8'h02); settle;
    chk("switch", 11'h0, {10'h0, switch_mode});
    wr(8'h51, 8'h00); settle;
    chk("switch", 11'h1, {10'h0, switch_mode});
    rd(8'h52, 8'h02); wr(8'h52, 8'h00);
  endtask : t_mode
  task t_pin0;
    @(posedge clk) multipurpose_control_pin <= 8'h00;
    wr(8'h52, 8'h18); wr(8'h51, 8'h01); en(1'b0);
    @(posedge clk) multipurpose_control_pin <= 8'h01;
    en(1'b1);
    chk("switch", 11'h1, {10'h0, switch_mode});
    @(posedge clk) multipurpose_control_pin <= 8'h00;
    en(1'b0);
    wr(8'h52, 8'h10);
    en(1'b1);
    // Pin 0 as mode select; regulator off so the mode latch is open
    wr(8'h51, 8'h00);
    wr(8'h52, 8'h08);
    @(posedge clk) multipurpose_control_pin <= 8'h01;
    settle;
    chk("switch", 11'h1, {10'h0, switch_mode});
    @(posedge clk) multipurpose_control_pin <= 8'h00;
    settle;
    chk("switch", 11'h0, {10'h0, switch_mode});
  endtask : t_pin0
  task t_dsc;
    wr(8'h51, 8'h00); wr(8'h52, 8'h00); settle;
    chk("act_dsc", 11'h0, {10'h0, active_discharge});
    @(posedge clk) hard_reset_mode <= 1'b1;
    settle; chk("act_dsc", 11'h1, {10'h0, active_discharge});
    @(posedge clk) hard_reset_mode <= 1'b0;
    settle; chk("psv_dsc", 11'h0, {10'h0, passive_discharge});
    wr(8'h52, 8'h01); settle;
    chk("psv_dsc", 11'h1, {10'h0, passive_discharge});
    wr(8'h52, 8'h00);
    @(posedge clk) off_mode <= 1'b1;
    settle; chk("psv_dsc", 11'h1, {10'h0, passive_discharge});
    @(posedge clk) off_mode <= 1'b0;
    // Both select bits set: discharge only while the enable is low
    wr(8'h52, 8'h05);
    wr(8'h51, 8'h01);
    settle;
    chk("act_dsc", 11'h0, {10'h0, active_discharge});
    chk("psv_dsc", 11'h0, {10'h0, passive_discharge});
    wr(8'h51, 8'h00);
    settle;
    chk("act_dsc", 11'h1, {10'h0, active_discharge});
    chk("psv_dsc", 11'h1, {10'h0, passive_discharge});
    wr(8'h52, 8'h00);
  endtask : t_dsc
  task t_vset;
    foreach (codes[i])
    begin
      wr(8'h53, {2'h0, codes[i]}); settle;
      chk("vcode", {5'h0, codes[i]}, {5'h0, output_voltage_code});
      chk("mv", codes[i] > 6'h3A ? 11'h79E : 11'h1F4 + 11'(codes[i]) * 11'h019,
          output_voltage_mv);
    end
  endtask : t_vset
  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task final_report;
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hung handshake would otherwise stall the run forever
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      final_report;
    end
  end
  initial
  begin
    {arst_n, reg_wr, reg_rd, boot_done, hard_reset_mode, off_mode} = 6'h00;
    {boot_stage_0, boot_stage_25, boot_stage_50} = 3'h0;
    {reg_addr, reg_wdata, multipurpose_control_pin} = 24'h000000;
    power_up_slot = 3'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_regs; t_swen; t_pins; t_staged; t_mode; t_pin0; t_dsc; t_vset;
    final_report;
  end
endmodule : lrc_regulator_ctrl_tb
